// ### core/cbi_pkg.sv
package cbi_pkg;
  // timing
  localparam int CLK_NS = 10;
  localparam int MC_NS = 20;
  localparam int MC_CLKS = (MC_NS + CLK_NS - 1) / CLK_NS;
  localparam int MC_LAST = MC_CLKS - 1;
  localparam int IC_MAX = 15;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_CMD = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;

  // operation codes
  localparam logic [3:0] OP_FETCH = 4'h0;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_WRITE = 4'h2;
  localparam logic [3:0] OP_VREAD = 4'h3;
  localparam logic [3:0] OP_SREAD = 4'h4;
  localparam logic [3:0] OP_SWRITE = 4'h5;
  localparam logic [3:0] OP_HALT = 4'h6;
  localparam logic [3:0] OP_SLEEP = 4'h7;
  localparam logic [3:0] OP_EXC = 4'h8;

  // bus state codes
  localparam logic [1:0] BS_HIZ = 2'h0;
  localparam logic [1:0] BS_VEC = 2'h1;
  localparam logic [1:0] BS_WR = 2'h2;
  localparam logic [1:0] BS_RD = 2'h3;

  // reset and fixed values
  localparam logic [1:0] IFLAG_RST = 2'h3;
  localparam logic [1:0] IFLAG_NMI = 2'h3;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [1:0] PHASE_RST = 2'h1;
  localparam logic [7:0] PAGE_MIN = 8'h00;
  localparam logic [23:0] ADDR_RST = 24'h00_0000;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ACC = 6'b000010,
    ST_GRANT = 6'b000100,
    ST_HALT = 6'b001000,
    ST_WARN = 6'b010000,
    ST_SLEEP = 6'b100000
  } cbi_state_t;

  typedef struct packed {
    logic [26:0] rsvd;
    logic [2:0] mask;
    logic [1:0] iflags;
  } cbi_ctrl_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [3:0] op;
    logic [7:0] data;
  } cbi_cmd_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic stopped;
    logic [3:0] icnt;
    logic taken_nmi;
    logic [1:0] taken_lvl;
    logic [2:0] irq_pend;
    logic nmi_pend;
    logic [3:0] cc;
    logic mode;
    logic granted;
    logic busy;
    logic [7:0] rdata;
  } cbi_stat_t;

  // pin inputs gathered for the synchroniser
  typedef struct packed {
    logic wait_n;
    logic rst_n;
    logic mode;
    logic [3:0] cc;
    logic bus_request_n_n;
    logic [7:0] sp;
    logic nmi_n;
    logic [2:0] irq_n;
    logic blk_n;
    logic [7:0] data;
  } cbi_pins_t;

  localparam cbi_pins_t PINS_IDLE = '1;
endpackage

// ### core/cbi_core_bus_if.sv
`timescale 1ns/1ps
// Behaviour
// - instruction spans one to fifteen machine cycles
// - two phase outputs divided from clock
// - 24-bit address out, 8-bit data both ways
// - wait low stretches the current access
// - read and write strobes low during access
// - vector strobe low only on vector read
// - reset input low forces reset state
// - mode low minimum, high maximum
// - sleep warning rises before sleep entry
// - bus request releases address, data, strobes
// - grant output low once bus released
// - stack accesses put page on upper address
// - unmaskable interrupt taken on falling edge
// - three maskable levels, each software maskable
// - block input low ignores all interrupts
// - taken output low on interrupt accept
// - taken output low on reset, zero divide
// - priority flags driven on status outputs
// - first fetch marker; interrupts sampled there
// - stop low in halt, sleep, bus release
// - bus state code per access kind
module cbi_core_bus_if (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock outputs
  output logic [1:0] phase_clock_outputs,
  // address and data
  output logic [23:0] address_out,
  output logic address_oe,
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  // bus control
  input wire logic wait_n,
  output logic rd_n,
  output logic wr_n,
  output logic strobe_oe,
  output logic vector_read_n,
  output logic [1:0] bus_state_code,
  // system control
  input wire logic reset_in_n,
  input wire logic mode_in,
  input wire logic [3:0] custom_condition_inputs,
  output logic sleep_warning,
  input wire logic bus_request_n,
  output logic bus_grant_n,
  input wire logic [7:0] stack_page_in,
  // interrupts
  input wire logic nmi_n,
  input wire logic interrupt_level_three_n,
  input wire logic interrupt_level_two_n,
  input wire logic interrupt_level_one_n,
  input wire logic interrupt_block_n,
  output logic interrupt_taken_n,
  // status
  output logic [1:0] priority_flag_outputs,
  output logic first_fetch,
  output logic stop_n
);

  function automatic logic is_rd_op(input logic [3:0] op);
    return op == cbi_pkg::OP_FETCH || op == cbi_pkg::OP_READ ||
           op == cbi_pkg::OP_SREAD;
  endfunction

  function automatic logic is_wr_op(input logic [3:0] op);
    return op == cbi_pkg::OP_WRITE || op == cbi_pkg::OP_SWRITE;
  endfunction

  function automatic logic is_stk_op(input logic [3:0] op);
    return op == cbi_pkg::OP_SREAD || op == cbi_pkg::OP_SWRITE;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return a == cbi_pkg::OFS_CTRL || a == cbi_pkg::OFS_ADDR ||
           a == cbi_pkg::OFS_CMD || a == cbi_pkg::OFS_STAT;
  endfunction

  cbi_pkg::cbi_pins_t pin_a;
  cbi_pkg::cbi_pins_t s1_r;
  cbi_pkg::cbi_pins_t s2_r;
  cbi_pkg::cbi_state_t state_r;
  cbi_pkg::cbi_state_t state_nxt;
  cbi_pkg::cbi_cmd_t cmd_r;
  cbi_pkg::cbi_cmd_t cmd_new;
  cbi_pkg::cbi_cmd_t cmd_nxt;
  cbi_pkg::cbi_ctrl_t ctrl_w;
  cbi_pkg::cbi_stat_t stat_v;
  logic [31:0] rd_val;
  logic [23:0] addr_r;
  logic [2:0] mask_r;
  logic [3:0] cnt_r;
  logic [3:0] icnt_r;
  logic [3:0] tk_r;
  logic [3:0] tk_nxt;
  logic [7:0] rdata_r;
  logic [2:0] ok_lv;
  logic [1:0] pick_lv;
  logic [1:0] taken_lvl_r;
  logic taken_nmi_r;
  logic nmi_d_r;
  logic nmi_pend_r;
  logic rst_d_r;
  logic ok_r;
  logic cpu_rst;
  logic wr_acc;
  logic start;
  logic cmd_ok;
  logic acc_int;
  logic wake;
  logic acc_end;
  logic acc_nxt;
  logic cmd_sel;

  // every pin input passes two flops before use
  assign pin_a = {wait_n, reset_in_n, mode_in, custom_condition_inputs,
                  bus_request_n, stack_page_in, nmi_n,
                  interrupt_level_three_n, interrupt_level_two_n,
                  interrupt_level_one_n, interrupt_block_n, data_lines_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= cbi_pkg::PINS_IDLE;
      s2_r <= cbi_pkg::PINS_IDLE;
    end else begin
      s1_r <= pin_a;
      s2_r <= s1_r;
    end
  end

  assign cpu_rst = !s2_r.rst_n;
  assign ctrl_w = pwdata;
  assign cmd_new = pwdata;
  assign cmd_sel = psel && paddr == cbi_pkg::OFS_CMD;
  assign wr_acc = psel && penable && pwrite && pready;
  assign start = wr_acc && paddr == cbi_pkg::OFS_CMD && ok_r && !cpu_rst;
  assign cmd_nxt = start ? cmd_new : cmd_r;
  assign acc_end = cnt_r == 4'(cbi_pkg::MC_LAST);

  // an op only starts from idle; no op but a fetch past the cycle limit
  assign cmd_ok = state_r == cbi_pkg::ST_IDLE && !cpu_rst &&
                  cmd_new.op <= cbi_pkg::OP_EXC &&
                  (cmd_new.op == cbi_pkg::OP_FETCH ||
                   icnt_r < 4'(cbi_pkg::IC_MAX));

  // level i+1 is eligible when unmasked and above the current flags
  generate
    for (genvar i = 0; i < 3; i++) begin : g_lv
      assign ok_lv[i] = !s2_r.irq_n[i] && !mask_r[i] &&
                        2'(i + 1) > priority_flag_outputs;
    end
  endgenerate

  always_comb begin
    pick_lv = 2'h0;
    if (ok_lv[2]) pick_lv = 2'h3;
    else if (ok_lv[1]) pick_lv = 2'h2;
    else if (ok_lv[0]) pick_lv = 2'h1;
  end

  // sampled only as a first fetch starts, and never while blocked
  assign acc_int = start && cmd_new.op == cbi_pkg::OP_FETCH &&
                   s2_r.blk_n && (nmi_pend_r || |ok_lv);
  assign wake = s2_r.blk_n && (nmi_pend_r || |ok_lv);

  always_comb begin
    state_nxt = state_r;
    if (cpu_rst) begin
      state_nxt = cbi_pkg::ST_IDLE;
    end else begin
      case (state_r)
        cbi_pkg::ST_IDLE: begin
          if (start) begin
            if (cmd_new.op == cbi_pkg::OP_HALT) begin
              state_nxt = cbi_pkg::ST_HALT;
            end else if (cmd_new.op == cbi_pkg::OP_SLEEP) begin
              state_nxt = cbi_pkg::ST_WARN;
            end else if (cmd_new.op != cbi_pkg::OP_EXC) begin
              state_nxt = cbi_pkg::ST_ACC;
            end
          end else if (!s2_r.bus_request_n_n && !cmd_sel) begin
            state_nxt = cbi_pkg::ST_GRANT;
          end
        end
        cbi_pkg::ST_ACC: begin
          if (acc_end && s2_r.wait_n) begin
            state_nxt = cbi_pkg::ST_IDLE;
          end
        end
        cbi_pkg::ST_GRANT: begin
          if (s2_r.bus_request_n_n) begin
            state_nxt = cbi_pkg::ST_IDLE;
          end
        end
        cbi_pkg::ST_WARN: begin
          if (acc_end) begin
            state_nxt = cbi_pkg::ST_SLEEP;
          end
        end
        cbi_pkg::ST_HALT, cbi_pkg::ST_SLEEP: begin
          if (wake) begin
            state_nxt = cbi_pkg::ST_IDLE;
          end
        end
        default: state_nxt = cbi_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cbi_pkg::ST_IDLE;
      cmd_r <= '0;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      if (start) begin
        cnt_r <= '0;
      end else if (!acc_end) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // machine cycles per instruction, restarted by each first fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt_r <= '0;
    end else if (cpu_rst) begin
      icnt_r <= '0;
    end else if (start && cmd_new.op == cbi_pkg::OP_FETCH) begin
      icnt_r <= 4'h1;
    end else if (start && icnt_r < 4'(cbi_pkg::IC_MAX)) begin
      icnt_r <= icnt_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_clock_outputs <= cbi_pkg::PHASE_RST;
    end else begin
      phase_clock_outputs <= ~phase_clock_outputs;
    end
  end

  // pins follow the next state so they line up with it
  assign acc_nxt = state_nxt == cbi_pkg::ST_ACC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_out <= cbi_pkg::ADDR_RST;
      address_oe <= 1'b1;
      data_lines_out <= '0;
      data_lines_oe <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      strobe_oe <= 1'b1;
      vector_read_n <= 1'b1;
      bus_state_code <= cbi_pkg::BS_HIZ;
      first_fetch <= 1'b0;
    end else begin
      if (is_stk_op(cmd_nxt.op)) begin
        address_out <= {s2_r.sp, addr_r[15:0]};
      end else if (s2_r.mode) begin
        address_out <= addr_r;
      end else begin
        address_out <= {cbi_pkg::PAGE_MIN, addr_r[15:0]};
      end
      address_oe <= state_nxt != cbi_pkg::ST_GRANT;
      strobe_oe <= state_nxt != cbi_pkg::ST_GRANT;
      data_lines_out <= cmd_nxt.data;
      data_lines_oe <= acc_nxt && is_wr_op(cmd_nxt.op);
      rd_n <= !(acc_nxt && is_rd_op(cmd_nxt.op));
      wr_n <= !(acc_nxt && is_wr_op(cmd_nxt.op));
      vector_read_n <= !(acc_nxt && cmd_nxt.op == cbi_pkg::OP_VREAD);
      if (!acc_nxt) begin
        bus_state_code <= cbi_pkg::BS_HIZ;
      end else if (cmd_nxt.op == cbi_pkg::OP_VREAD) begin
        bus_state_code <= cbi_pkg::BS_VEC;
      end else if (is_wr_op(cmd_nxt.op)) begin
        bus_state_code <= cbi_pkg::BS_WR;
      end else begin
        bus_state_code <= cbi_pkg::BS_RD;
      end
      first_fetch <= acc_nxt && cmd_nxt.op == cbi_pkg::OP_FETCH;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_grant_n <= 1'b1;
      stop_n <= 1'b1;
      sleep_warning <= 1'b0;
    end else begin
      bus_grant_n <= state_nxt != cbi_pkg::ST_GRANT;
      stop_n <= !(state_nxt == cbi_pkg::ST_GRANT ||
                  state_nxt == cbi_pkg::ST_HALT ||
                  state_nxt == cbi_pkg::ST_SLEEP);
      // stays high through sleep so the oscillator remains stopped
      sleep_warning <= state_nxt == cbi_pkg::ST_WARN ||
                       state_nxt == cbi_pkg::ST_SLEEP;
    end
  end

  // read data is taken from the synchronised lines at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
    end else if (state_r == cbi_pkg::ST_ACC && acc_end && s2_r.wait_n &&
                 cmd_r.op != cbi_pkg::OP_WRITE &&
                 cmd_r.op != cbi_pkg::OP_SWRITE) begin
      rdata_r <= s2_r.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_d_r <= 1'b1;
      rst_d_r <= 1'b1;
    end else begin
      nmi_d_r <= s2_r.nmi_n;
      rst_d_r <= s2_r.rst_n;
    end
  end

  // a new falling edge wins over the clear by acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend_r <= 1'b0;
    end else if (cpu_rst) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_d_r && !s2_r.nmi_n && s2_r.blk_n) begin
      nmi_pend_r <= 1'b1;
    end else if (acc_int) begin
      nmi_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_flag_outputs <= cbi_pkg::IFLAG_RST;
      mask_r <= cbi_pkg::MASK_RST;
      taken_lvl_r <= '0;
      taken_nmi_r <= 1'b0;
    end else if (cpu_rst) begin
      priority_flag_outputs <= cbi_pkg::IFLAG_RST;
      mask_r <= cbi_pkg::MASK_RST;
    end else if (acc_int) begin
      taken_nmi_r <= nmi_pend_r;
      taken_lvl_r <= nmi_pend_r ? cbi_pkg::IFLAG_NMI : pick_lv;
      priority_flag_outputs <= nmi_pend_r ? cbi_pkg::IFLAG_NMI
                                          : pick_lv;
    end else if (wr_acc && paddr == cbi_pkg::OFS_CTRL) begin
      priority_flag_outputs <= ctrl_w.iflags;
      mask_r <= ctrl_w.mask;
    end
  end

  // one machine cycle low per accepted interrupt or exception
  always_comb begin
    tk_nxt = tk_r;
    if (acc_int || (start && cmd_new.op == cbi_pkg::OP_EXC) ||
        (!rst_d_r && s2_r.rst_n)) begin
      tk_nxt = 4'(cbi_pkg::MC_CLKS);
    end else if (tk_r != 4'h0) begin
      tk_nxt = tk_r - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk_r <= '0;
      interrupt_taken_n <= 1'b1;
    end else begin
      tk_r <= tk_nxt;
      interrupt_taken_n <= tk_nxt == 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= cbi_pkg::ADDR_RST;
    end else if (wr_acc && paddr == cbi_pkg::OFS_ADDR) begin
      addr_r <= pwdata[23:0];
    end
  end

  always_comb begin
    stat_v = '0;
    stat_v.rdata = rdata_r;
    stat_v.busy = state_r != cbi_pkg::ST_IDLE;
    stat_v.granted = !bus_grant_n;
    stat_v.mode = s2_r.mode;
    stat_v.cc = s2_r.cc;
    stat_v.nmi_pend = nmi_pend_r;
    stat_v.irq_pend = ok_lv;
    stat_v.taken_lvl = taken_lvl_r;
    stat_v.taken_nmi = taken_nmi_r;
    stat_v.icnt = icnt_r;
    stat_v.stopped = !stop_n;
  end

  always_comb begin
    rd_val = '0;
    if (paddr == cbi_pkg::OFS_CTRL) begin
      rd_val = {27'h000_0000, mask_r, priority_flag_outputs};
    end else if (paddr == cbi_pkg::OFS_ADDR) begin
      rd_val = {8'h00, addr_r};
    end else if (paddr == cbi_pkg::OFS_CMD) begin
      rd_val = cmd_r;
    end else if (paddr == cbi_pkg::OFS_STAT) begin
      rd_val = stat_v;
    end
  end

  // no wait state: pready and prdata come from flops loaded in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      ok_r <= 1'b0;
    end else if (psel && !penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= !is_mapped(paddr) || (pwrite && cmd_sel && !cmd_ok);
      ok_r <= cmd_ok;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence warn_held;
    $past(sleep_warning, 2) && $past(sleep_warning) && $past(stop_n);
  endsequence

  sequence taken_low;
    (!interrupt_taken_n) [*2] ##1 interrupt_taken_n;
  endsequence

  chk_warn_before_sleep:
    assert property ($rose(!stop_n && sleep_warning) |-> warn_held)
    else $error("sleep entered without prior warning");
  chk_grant_release:
    assert property (!bus_grant_n |-> !address_oe && !data_lines_oe &&
                     !strobe_oe && bus_state_code == cbi_pkg::BS_HIZ)
    else $error("bus driven while granted");
  chk_grant_cause:
    assert property ($fell(bus_grant_n) |-> $past(!s2_r.bus_request_n_n))
    else $error("grant without request");
  chk_read_strobe:
    assert property ($fell(rd_n) |-> (!rd_n) [*2])
    else $error("read strobe shorter than a machine cycle");
  chk_vector_code:
    assert property (!vector_read_n |-> rd_n && wr_n &&
                     bus_state_code == cbi_pkg::BS_VEC)
    else $error("vector strobe with wrong code");
  chk_wait_stretch:
    assert property (state_r == cbi_pkg::ST_ACC && acc_end &&
                     !s2_r.wait_n |=> state_r == cbi_pkg::ST_ACC &&
                     bus_state_code != cbi_pkg::BS_HIZ)
    else $error("access ended while wait low");
  chk_stop_states:
    assert property (!stop_n |-> !bus_grant_n ||
                     state_r == cbi_pkg::ST_HALT ||
                     state_r == cbi_pkg::ST_SLEEP)
    else $error("stop low in a running state");
  chk_stack_page:
    assert property (state_r == cbi_pkg::ST_ACC && is_stk_op(cmd_r.op)
                     |-> address_out[23:16] == $past(s2_r.sp))
    else $error("stack page missing on address");
  chk_taken_pulse:
    assert property ($fell(interrupt_taken_n) |-> taken_low)
    else $error("taken pulse not one machine cycle");
  chk_block_ignore:
    assert property ($fell(interrupt_taken_n) && first_fetch
                     |-> $past(s2_r.blk_n))
    else $error("interrupt taken while blocked");
  chk_priority_pick:
    assert property (acc_int && !nmi_pend_r && ok_lv[2] |=>
                     taken_lvl_r == 2'h3 && priority_flag_outputs == 2'h3)
    else $error("lower level taken over level three");
  // the divider still holds its reset value for an edge after release
  chk_phase_pair:
    assert property (phase_clock_outputs[0] != phase_clock_outputs[1] &&
                     (!$past(presetn, 2) ||
                      phase_clock_outputs != $past(phase_clock_outputs)))
    else $error("phase outputs not a toggling pair");
  chk_cycle_limit:
    assert property (start && cmd_new.op != cbi_pkg::OP_FETCH |->
                     icnt_r < 4'(cbi_pkg::IC_MAX))
    else $error("instruction beyond cycle limit");
  chk_reset_state:
    assert property (!s2_r.rst_n |=> state_r == cbi_pkg::ST_IDLE &&
                     rd_n && wr_n ##1 stop_n)
    else $error("reset did not idle the bus");

endmodule

// ### test/cbi_mem_model.sv
`timescale 1ns/1ps
module cbi_mem_model (
  // clock
  input wire logic pclk,
  // from the core; slow comes from the testbench
  input wire logic rd_n,
  input wire logic [23:0] address_out,
  input wire logic slow,
  // to the core
  output logic [7:0] data_lines_in,
  output logic wait_n
);
  logic [7:0] last_r = 8'h00;
  int cnt_r = 0;
  // slow: wait already low before the read, so the synced copy is ready
  assign wait_n = !(slow && cnt_r < 6);
  // released bus shows the inverse, not a stale copy
  assign data_lines_in = rd_n ? ~last_r : address_out[7:0] ^ 8'h5a;
  always @(posedge pclk) begin
    cnt_r <= rd_n ? 0 : cnt_r + 1;
    if (!rd_n) last_r <= address_out[7:0] ^ 8'h5a;
  end
endmodule

// ### test/cbi_core_bus_if_tb.sv
`timescale 1ns/1ps
module cbi_core_bus_if_tb;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r, a, d;
  logic pready, pslverr, address_oe, data_lines_oe, rd_n, wr_n;
  logic strobe_oe, vector_read_n, sleep_warning, bus_grant_n;
  logic interrupt_taken_n, first_fetch, stop_n, wait_n, slow = 1'b0;
  logic [1:0] phase_clock_outputs, bus_state_code, priority_flag_outputs;
  logic [1:0] rc, wc, vc;
  logic [23:0] address_out, ra, wa;
  logic [7:0] data_lines_in, data_lines_out, wd, sp;
  logic [3:0] cc;
  logic rin_n = 1'b1, brq_n = 1'b1, blk_n = 1'b1, l3_n = 1'b1, l1_n = 1'b1;
  logic nmi = 1'b1, md = 1'b0;
  int n_errors = 0, checks = 0, tk = 0, rl = 0, wl = 0, sw = 0, ff = 0, i;
  logic [31:0] eq[$], mq[$];
  logic sq[$];

  cbi_core_bus_if u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .phase_clock_outputs,
    .address_out, .address_oe, .data_lines_in, .data_lines_out,
    .data_lines_oe, .wait_n, .rd_n, .wr_n, .strobe_oe, .vector_read_n,
    .bus_state_code, .reset_in_n(rin_n), .mode_in(md),
    .custom_condition_inputs(cc), .sleep_warning,
    .bus_request_n(brq_n), .bus_grant_n, .stack_page_in(sp),
    .nmi_n(nmi), .interrupt_level_three_n(l3_n),
    .interrupt_level_two_n(1'b1), .interrupt_level_one_n(l1_n),
    .interrupt_block_n(blk_n), .interrupt_taken_n,
    .priority_flag_outputs, .first_fetch, .stop_n);
  cbi_mem_model u_mem (.pclk, .rd_n, .address_out, .slow,
    .data_lines_in, .wait_n);

  always #5 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic lim(input int k);
    if (k >= 60) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t pin got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_rd(input logic [31:0] e, m, input logic s);
    checks++;
    if ((prdata & m) !== (e & m) || pslverr !== s) begin
      n_errors++;
      $display("[FAIL] %0t apb got %h exp %h", $time, prdata, e);
    end
  endtask

  // writes keep a zero mask: only the error flag is compared
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] dt, m, input logic e);
    int k;
    eq.push_back(dt);
    mq.push_back(w ? 32'h0000_0000 : m);
    sq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 60);
    lim(k);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [7:0] dv);
    int k;
    apb(1'b1, cbi_pkg::OFS_ADDR, a, 0, 1'b0);
    apb(1'b1, cbi_pkg::OFS_CMD, {20'h0_0000, op, dv}, 0, 1'b0);
    k = 0;
    do begin
      apb(1'b0, cbi_pkg::OFS_STAT, 0, 0, 1'b0);
      k++;
    end while (r[8] !== 1'b0 && k < 60);
    lim(k);
  endtask

  always @(posedge pclk) begin
    if (!rd_n) begin
      rl <= rl + 1;
      ra <= address_out;
      rc <= bus_state_code;
    end
    if (!wr_n) begin
      wl <= wl + 1;
      wa <= address_out;
      wd <= data_lines_oe ? data_lines_out : 8'hxx;
      wc <= bus_state_code;
    end
    if (!vector_read_n) vc <= bus_state_code;
    if (!interrupt_taken_n) tk <= tk + 1;
    if (first_fetch) ff <= ff + 1;
    if (sleep_warning && stop_n) sw <= sw + 1;
    if (psel && penable && pready === 1'b1)
      cmp_rd(eq.pop_front(), mq.pop_front(), sq.pop_front());
  end

  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    int t;
    r = $urandom(32'h591e_8429);
    a = $urandom;
    d = $urandom;
    cc = $urandom;
    sp = $urandom;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(priority_flag_outputs, cbi_pkg::IFLAG_RST);
    chk(phase_clock_outputs[0] ^ phase_clock_outputs[1], 1);
    apb(1'b0, cbi_pkg::OFS_CTRL, 32'h0000_0003, 32'h0000_001f, 1'b0);
    apb(1'b0, 12'h010, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    t = wl;
    cmd(cbi_pkg::OP_WRITE, d[7:0]);
    chk(wl - t, 2);
    chk(wa, {8'h00, a[15:0]});
    chk(wd, d[7:0]);
    chk(wc, cbi_pkg::BS_WR);
    slow <= 1'b1;
    t = rl;
    cmd(cbi_pkg::OP_SREAD, 8'h00);
    slow <= 1'b0;
    chk(rl - t > 6, 1);
    chk(ra, {sp, a[15:0]});
    chk(rc, cbi_pkg::BS_RD);
    apb(1'b0, cbi_pkg::OFS_STAT, {17'h0_0000, cc, 3'h0, a[7:0] ^ 8'h5a},
        32'h0000_78ff, 1'b0);
    md <= 1'b1;
    cmd(cbi_pkg::OP_READ, 8'h00);
    chk(ra, a[23:0]);
    cmd(cbi_pkg::OP_VREAD, 8'h00);
    chk(vc, cbi_pkg::BS_VEC);
    t = tk;
    cmd(cbi_pkg::OP_EXC, 8'h00);
    chk(tk - t, 2);
    // levels three and one together, then three masked, then blocked
    apb(1'b1, cbi_pkg::OFS_CTRL, 32'h0000_0000, 0, 1'b0);
    l3_n <= 1'b0;
    l1_n <= 1'b0;
    t = tk;
    cmd(cbi_pkg::OP_FETCH, 8'h00);
    chk(tk - t, 2);
    chk(priority_flag_outputs, 2'h3);
    chk(ff, 2);
    apb(1'b1, cbi_pkg::OFS_CTRL, 32'h0000_0010, 0, 1'b0);
    t = tk;
    cmd(cbi_pkg::OP_FETCH, 8'h00);
    chk(tk - t, 2);
    chk(priority_flag_outputs, 2'h1);
    // every level masked: only the unmaskable edge can be taken
    apb(1'b1, cbi_pkg::OFS_CTRL, 32'h0000_001c, 0, 1'b0);
    nmi <= 1'b0;
    t = tk;
    cmd(cbi_pkg::OP_FETCH, 8'h00);
    chk(tk - t, 2);
    chk(priority_flag_outputs, cbi_pkg::IFLAG_NMI);
    apb(1'b1, cbi_pkg::OFS_CTRL, 32'h0000_0000, 0, 1'b0);
    blk_n <= 1'b0;
    t = tk;
    cmd(cbi_pkg::OP_FETCH, 8'h00);
    chk(tk - t, 0);
    l3_n <= 1'b1;
    l1_n <= 1'b1;
    blk_n <= 1'b1;
    t = sw;
    apb(1'b1, cbi_pkg::OFS_CMD, {20'h0_0000, cbi_pkg::OP_SLEEP, 8'h00},
        0, 1'b0);
    for (i = 0; i < 60 && stop_n !== 1'b0; i++) @(posedge pclk);
    lim(i);
    chk(sw - t, 2);
    chk(sleep_warning, 1);
    l1_n <= 1'b0;
    for (i = 0; i < 60 && stop_n !== 1'b1; i++) @(posedge pclk);
    lim(i);
    l1_n <= 1'b1;
    apb(1'b1, cbi_pkg::OFS_CMD, {20'h0_0000, cbi_pkg::OP_HALT, 8'h00},
        0, 1'b0);
    chk({stop_n, sleep_warning}, 0);
    l1_n <= 1'b0;
    for (i = 0; i < 60 && stop_n !== 1'b1; i++) @(posedge pclk);
    lim(i);
    l1_n <= 1'b1;
    brq_n <= 1'b0;
    for (i = 0; i < 60 && bus_grant_n !== 1'b0; i++) @(posedge pclk);
    lim(i);
    chk({address_oe, strobe_oe, data_lines_oe}, 0);
    chk(stop_n, 0);
    chk(bus_state_code, cbi_pkg::BS_HIZ);
    apb(1'b1, cbi_pkg::OFS_CMD, 32'h0000_0100, 0, 1'b1);
    brq_n <= 1'b1;
    for (i = 0; i < 60 && bus_grant_n !== 1'b1; i++) @(posedge pclk);
    lim(i);
    rin_n <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(priority_flag_outputs, 2'h3);
    t = tk;
    rin_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(tk - t, 2);
    tally_and_finish();
  end
endmodule
